// ==== mdu_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module mdu_device (
  input  wire logic clk,
  input  wire logic rst_n,
  mdu_bus_if.device bus
);
  import mdu_pkg::*;

  logic [31:0] acc_r;
  logic [15:0] opb_r;
  logic [15:0] rem_r;
  logic [7:0]  ctrl_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic        irq_r;
  logic [7:0]  ctrl_wr;
  logic        ctrl_wr_hit;
  logic        start;
  logic        last;
  logic [16:0] div_try;
  logic [16:0] div_shift;
  logic [15:0] mul_sum_hi;
  logic        mul_carry;

  // ---------------------------------------------------------------
  // Control register write decode
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_wr     = ctrl_r;
    ctrl_wr_hit = 1'b0;
    if (bus.addr == MDU_ADDR_CTRL && bus.wr_en) begin
      ctrl_wr     = bus.wdata & MDU_CTRL_MASK;
      ctrl_wr_hit = 1'b1;
    end else if (bus.addr == MDU_ADDR_CTRL && bus.bit_wr) begin
      // A single-bit write edits one bit of the present value.
      ctrl_wr               = ctrl_r;
      ctrl_wr[bus.bit_sel]  = bus.bit_val;
      ctrl_wr               = ctrl_wr & MDU_CTRL_MASK;
      ctrl_wr_hit           = 1'b1;
    end
  end

  // A start is a write that raises the run bit while it is low; rewriting
  // a run bit that is already set leaves the running operation alone.
  assign start = ctrl_wr_hit && ctrl_wr[MDU_RUN_BIT] && !ctrl_r[MDU_RUN_BIT];
  // The counter stands at one in the cycle before the final iteration edge.
  assign last  = busy_r && (cnt_r == 6'd1);

  // ---------------------------------------------------------------
  // Control register and sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= MDU_CTRL_RST;
    end else if (last) begin
      // Completion beats a concurrent clear: the result stands either way.
      ctrl_r <= ctrl_wr & ~MDU_CTRL_RUN_CLR();
    end else if (ctrl_wr_hit) begin
      ctrl_r <= ctrl_wr;
    end
  end

  // Mask that drops the run bit on the completion edge.
  function automatic logic [7:0] MDU_CTRL_RUN_CLR();
    logic [7:0] m;
    m              = 8'h00;
    m[MDU_RUN_BIT] = 1'b1;
    return m;
  endfunction : MDU_CTRL_RUN_CLR

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r  <= 6'd0;
    end else if (start) begin
      busy_r <= 1'b1;
      cnt_r  <= ctrl_wr[MDU_MODE_BIT] ? MDU_MUL_CYCLES : MDU_DIV_CYCLES;
    end else if (last) begin
      busy_r <= 1'b0;
      cnt_r  <= 6'd0;
    end else if (busy_r && ctrl_wr_hit && !ctrl_wr[MDU_RUN_BIT]) begin
      // A software clear before the final edge abandons the operation.
      busy_r <= 1'b0;
      cnt_r  <= 6'd0;
    end else if (busy_r) begin
      cnt_r  <= cnt_r - 6'd1;
    end
  end

  // ---------------------------------------------------------------
  // Completion interrupt, raised on the same edge as the run bit falls
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      // Raised on the same edge that stores the result and clears the run bit.
      irq_r <= last;
    end
  end
  assign bus.completion_irq = irq_r;

  // ---------------------------------------------------------------
  // Datapath: one iteration per clock
  // ---------------------------------------------------------------
  assign {mul_carry, mul_sum_hi} = acc_r[0] ? {1'b0, acc_r[31:16]} + {1'b0, opb_r}
                                            : {1'b0, acc_r[31:16]};
  assign div_shift = {rem_r, acc_r[31]};
  assign div_try   = div_shift - {1'b0, opb_r};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= {MDU_HALF_RST, MDU_HALF_RST};
      rem_r <= MDU_HALF_RST;
    end else if (start) begin
      rem_r <= MDU_HALF_RST;
      if (ctrl_wr[MDU_MODE_BIT]) begin
        acc_r[31:16] <= MDU_HALF_RST;
      end
    end else if (busy_r && !(ctrl_wr_hit && !ctrl_wr[MDU_RUN_BIT] && !last)) begin
      if (ctrl_r[MDU_MODE_BIT]) begin
        // Product builds in the upper half while the multiplier shifts out.
        acc_r <= {mul_carry, mul_sum_hi, acc_r[15:1]};
      end else if (!div_try[16]) begin
        // Keep the trial difference only when the subtraction did not borrow.
        rem_r <= div_try[15:0];
        acc_r <= {acc_r[30:0], 1'b1};
      end else begin
        rem_r <= div_shift[15:0];
        acc_r <= {acc_r[30:0], 1'b0};
      end
    end else if (!busy_r && bus.wr_en) begin
      // Operand A is locked while running so the iteration is not disturbed.
      if (bus.addr == MDU_ADDR_A_LL) begin
        acc_r[7:0] <= bus.wdata;
      end else if (bus.addr == MDU_ADDR_A_LH) begin
        acc_r[15:8] <= bus.wdata;
      end else if (bus.addr == MDU_ADDR_A_HL) begin
        acc_r[23:16] <= bus.wdata;
      end else if (bus.addr == MDU_ADDR_A_HH) begin
        acc_r[31:24] <= bus.wdata;
      end
    end
  end

  // Operand B stays writable at all times; changing it mid-run is a software fault.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opb_r <= MDU_HALF_RST;
    end else if (bus.wr_en && bus.addr == MDU_ADDR_B_L) begin
      opb_r[7:0] <= bus.wdata;
    end else if (bus.wr_en && bus.addr == MDU_ADDR_B_H) begin
      opb_r[15:8] <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Reads during a run show intermediate values, which software must ignore.
  always_comb begin
    if (bus.addr == MDU_ADDR_A_LL) begin
      bus.rdata = acc_r[7:0];
    end else if (bus.addr == MDU_ADDR_A_LH) begin
      bus.rdata = acc_r[15:8];
    end else if (bus.addr == MDU_ADDR_A_HL) begin
      bus.rdata = acc_r[23:16];
    end else if (bus.addr == MDU_ADDR_A_HH) begin
      bus.rdata = acc_r[31:24];
    end else if (bus.addr == MDU_ADDR_B_L) begin
      bus.rdata = opb_r[7:0];
    end else if (bus.addr == MDU_ADDR_B_H) begin
      bus.rdata = opb_r[15:8];
    end else if (bus.addr == MDU_ADDR_REM_L) begin
      bus.rdata = rem_r[7:0];
    end else if (bus.addr == MDU_ADDR_REM_H) begin
      bus.rdata = rem_r[15:8];
    end else if (bus.addr == MDU_ADDR_CTRL) begin
      bus.rdata = ctrl_r;
    end else begin
      bus.rdata = 8'h00;
    end
  end

endmodule : mdu_device
`default_nettype wire

// ==== mdu_pkg.sv ====
package mdu_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] MDU_ADDR_A_LL   = 16'hFF62;
  localparam logic [15:0] MDU_ADDR_A_LH   = 16'hFF63;
  localparam logic [15:0] MDU_ADDR_A_HL   = 16'hFF64;
  localparam logic [15:0] MDU_ADDR_A_HH   = 16'hFF65;
  localparam logic [15:0] MDU_ADDR_B_L    = 16'hFF66;
  localparam logic [15:0] MDU_ADDR_B_H    = 16'hFF67;
  localparam logic [15:0] MDU_ADDR_CTRL   = 16'hFF68;
  localparam logic [15:0] MDU_ADDR_REM_L  = 16'hFF60;
  localparam logic [15:0] MDU_ADDR_REM_H  = 16'hFF61;

  // ---------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------
  localparam int          MDU_RUN_BIT     = 7;
  localparam int          MDU_MODE_BIT    = 0;
  localparam logic [7:0]  MDU_CTRL_RST    = 8'h00;
  localparam logic [7:0]  MDU_CTRL_MASK   = 8'h81;
  localparam logic [15:0] MDU_HALF_RST    = 16'h0000;
  localparam logic [7:0]  MDU_CTRL_MUL    = 8'h81;
  localparam logic [7:0]  MDU_CTRL_DIV    = 8'h80;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [5:0]  MDU_MUL_CYCLES  = 6'd16;
  localparam logic [5:0]  MDU_DIV_CYCLES  = 6'd32;

  typedef enum logic [1:0] {
    MDU_HOST_IDLE,
    MDU_HOST_LOAD,
    MDU_HOST_WAIT,
    MDU_HOST_READ
  } mdu_host_state_e;

endpackage : mdu_pkg

// ==== mdu_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mdu_bus_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        bit_wr;
  logic [2:0]  bit_sel;
  logic        bit_val;
  logic [7:0]  rdata;
  logic        completion_irq;

  modport device (
    input  addr, wdata, wr_en, bit_wr, bit_sel, bit_val,
    output rdata, completion_irq
  );
  modport host (
    output addr, wdata, wr_en, bit_wr, bit_sel, bit_val,
    input  rdata, completion_irq
  );
endinterface : mdu_bus_if
`default_nettype wire

// ==== mdu_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module mdu_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  mdu_bus_if.host          bus,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_mul,
  input  wire logic [31:0] req_a,
  input  wire logic [15:0] req_b,
  output logic             rsp_valid,
  output logic [31:0]      rsp_result,
  output logic [15:0]      rsp_rem
);
  import mdu_pkg::*;

  mdu_host_state_e state_r;
  logic [3:0]      step_r;
  logic [31:0]     a_r;
  logic [15:0]     b_r;
  logic            mul_r;
  logic [31:0]     res_r;
  logic [15:0]     rem_r;
  logic            vld_r;

  assign req_ready  = (state_r == MDU_HOST_IDLE);
  assign rsp_valid  = vld_r;
  assign rsp_result = res_r;
  assign rsp_rem    = rem_r;

  // ---------------------------------------------------------------
  // Bus drive per step
  // ---------------------------------------------------------------
  always_comb begin
    bus.addr    = MDU_ADDR_CTRL;
    bus.wdata   = 8'h00;
    bus.wr_en   = 1'b0;
    bus.bit_wr  = 1'b0;
    bus.bit_sel = 3'd0;
    bus.bit_val = 1'b0;
    if (state_r == MDU_HOST_LOAD) begin
      bus.wr_en = 1'b1;
      case (step_r)
        4'd0: begin
          bus.addr  = MDU_ADDR_A_LL;
          bus.wdata = a_r[7:0];
        end
        4'd1: begin
          bus.addr  = MDU_ADDR_A_LH;
          bus.wdata = a_r[15:8];
        end
        4'd2: begin
          bus.addr  = MDU_ADDR_A_HL;
          bus.wdata = mul_r ? 8'h00 : a_r[23:16];
        end
        4'd3: begin
          bus.addr  = MDU_ADDR_A_HH;
          bus.wdata = mul_r ? 8'h00 : a_r[31:24];
        end
        4'd4: begin
          bus.addr  = MDU_ADDR_B_L;
          bus.wdata = b_r[7:0];
        end
        4'd5: begin
          bus.addr  = MDU_ADDR_B_H;
          bus.wdata = b_r[15:8];
        end
        default: begin
          bus.addr  = MDU_ADDR_CTRL;
          bus.wdata = mul_r ? MDU_CTRL_MUL : MDU_CTRL_DIV;
        end
      endcase
    end else if (state_r == MDU_HOST_READ) begin
      case (step_r)
        4'd0: bus.addr = MDU_ADDR_A_LL;
        4'd1: bus.addr = MDU_ADDR_A_LH;
        4'd2: bus.addr = MDU_ADDR_A_HL;
        4'd3: bus.addr = MDU_ADDR_A_HH;
        4'd4: bus.addr = MDU_ADDR_REM_L;
        default: bus.addr = MDU_ADDR_REM_H;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MDU_HOST_IDLE;
      step_r  <= 4'd0;
      a_r     <= 32'h0000_0000;
      b_r     <= 16'h0000;
      mul_r   <= 1'b0;
      res_r   <= 32'h0000_0000;
      rem_r   <= 16'h0000;
      vld_r   <= 1'b0;
    end else begin
      vld_r <= 1'b0;
      case (state_r)
        MDU_HOST_IDLE: begin
          if (req_valid) begin
            a_r     <= req_a;
            b_r     <= req_b;
            mul_r   <= req_mul;
            step_r  <= 4'd0;
            state_r <= MDU_HOST_LOAD;
          end
        end
        MDU_HOST_LOAD: begin
          if (step_r == 4'd6) begin
            state_r <= MDU_HOST_WAIT;
          end else begin
            step_r <= step_r + 4'd1;
          end
        end
        MDU_HOST_WAIT: begin
          if (bus.completion_irq) begin
            step_r  <= 4'd0;
            state_r <= MDU_HOST_READ;
          end
        end
        default: begin
          case (step_r)
            4'd0: res_r[7:0]   <= bus.rdata;
            4'd1: res_r[15:8]  <= bus.rdata;
            4'd2: res_r[23:16] <= bus.rdata;
            4'd3: res_r[31:24] <= bus.rdata;
            4'd4: rem_r[7:0]   <= bus.rdata;
            default: rem_r[15:8] <= bus.rdata;
          endcase
          if (step_r == 4'd5) begin
            vld_r   <= 1'b1;
            state_r <= MDU_HOST_IDLE;
          end else begin
            step_r <= step_r + 4'd1;
          end
        end
      endcase
    end
  end

endmodule : mdu_host
`default_nettype wire

// ==== mdu_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mdu_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        bit_wr,
  input wire logic [2:0]  bit_sel,
  input wire logic        bit_val,
  input wire logic [7:0]  rdata,
  input wire logic        completion_irq
);
  import mdu_pkg::*;
  // ---------------------------------------------------------------
  // Start tracking
  // ---------------------------------------------------------------
  logic st_mul;
  logic st_div;
  logic busy_r;
  logic last_mul_r;
  assign st_mul = wr_en && addr == MDU_ADDR_CTRL && wdata == MDU_CTRL_MUL;
  assign st_div = wr_en && addr == MDU_ADDR_CTRL && wdata == MDU_CTRL_DIV;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_r <= 1'b0;
    else if (st_mul || st_div) busy_r <= 1'b1;
    else if (completion_irq) busy_r <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) last_mul_r <= 1'b0;
    else if (st_mul || st_div) last_mul_r <= st_mul;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet8;
    !completion_irq [*8];
  endsequence
  a_mul_done_time: assert property (
    st_mul |=> s_quiet8 ##1 s_quiet8 ##1 completion_irq) else $error("multiply end time wrong");
  a_div_done_time: assert property (
    st_div |=> s_quiet8 ##1 s_quiet8 ##1 s_quiet8 ##1 s_quiet8 ##1 completion_irq)
    else $error("divide end time wrong");
  a_irq_one_pulse: assert property (
    completion_irq |=> !completion_irq) else $error("completion pulse too long");
  a_irq_has_cause: assert property (
    $rose(completion_irq) |-> $past(st_mul, 17) || $past(st_div, 33))
    else $error("completion without start");
  a_ctrl_zero_bits: assert property (
    addr == MDU_ADDR_CTRL |-> rdata[6:1] == 6'h00) else $error("control bits 1-6 not zero");
  a_rem_zero_mul: assert property (
    !busy_r && last_mul_r && (addr == MDU_ADDR_REM_L || addr == MDU_ADDR_REM_H)
    |-> rdata == 8'h00) else $error("remainder not zero after multiply");
  a_host_quiet_busy: assert property (
    busy_r |-> !wr_en && !bit_wr) else $error("write while operation runs");
  a_ctrl_write_legal: assert property (
    wr_en && addr == MDU_ADDR_CTRL |-> wdata == MDU_CTRL_MUL || wdata == MDU_CTRL_DIV)
    else $error("illegal control write");
endmodule : mdu_chk
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mdu_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        req_valid;
  logic        req_ready;
  logic        req_mul;
  logic [31:0] req_a;
  logic [15:0] req_b;
  logic        rsp_valid;
  logic [31:0] rsp_result;
  logic [15:0] rsp_rem;
  int          failures;
  int          n_compared;
  mdu_bus_if bus ();
  mdu_bus_if bus2 ();
  mdu_host mdu_host_i (.clk(clk), .rst_n(rst_n), .bus(bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_mul(req_mul), .req_a(req_a), .req_b(req_b),
    .rsp_valid(rsp_valid), .rsp_result(rsp_result), .rsp_rem(rsp_rem));
  mdu_device mdu_device_i (.clk(clk), .rst_n(rst_n), .bus(bus));
  mdu_device mdu_device_i2 (.clk(clk), .rst_n(rst_n), .bus(bus2));
  mdu_chk mdu_chk_i (.clk(clk), .rst_n(rst_n), .addr(bus.addr), .wdata(bus.wdata),
    .wr_en(bus.wr_en), .bit_wr(bus.bit_wr), .bit_sel(bus.bit_sel), .bit_val(bus.bit_val),
    .rdata(bus.rdata), .completion_irq(bus.completion_irq));
  always #20 clk = ~clk;
  // ---------------------------------------------------------------
  // Helpers; the second device is driven straight from its bus.
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr2(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus2.addr = a;
    bus2.wdata = d;
    bus2.wr_en = 1'b1;
    @(negedge clk);
    bus2.wr_en = 1'b0;
  endtask : wr2
  task automatic bw2(input logic [2:0] s, input logic v);
    @(negedge clk);
    bus2.addr = MDU_ADDR_CTRL;
    bus2.bit_sel = s;
    bus2.bit_val = v;
    bus2.bit_wr = 1'b1;
    @(negedge clk);
    bus2.bit_wr = 1'b0;
  endtask : bw2
  task automatic rd2(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    bus2.addr = a;
    #1;
    chk({24'h0, bus2.rdata}, {24'h0, e});
  endtask : rd2
  task automatic ld2(input logic [31:0] a, input logic [15:0] b);
    logic [47:0] ab;
    ab = {b, a};
    for (int i = 0; i < 6; i++) wr2(MDU_ADDR_A_LL + 16'(i), ab[8*i +: 8]);
  endtask : ld2
  task automatic rd_res(input logic [31:0] q, input logic [15:0] r);
    for (int i = 0; i < 4; i++) rd2(MDU_ADDR_A_LL + 16'(i), q[8*i +: 8]);
    rd2(MDU_ADDR_REM_L, r[7:0]);
    rd2(MDU_ADDR_REM_H, r[15:8]);
  endtask : rd_res
  task automatic run2(input logic m, input logic [31:0] a, input logic [15:0] b);
    logic [31:0] q;
    q = m ? a[15:0] * b : a / b;
    ld2(a, b);
    wr2(MDU_ADDR_CTRL, {1'b1, 6'h00, m});
    repeat (m ? 14 : 30) @(negedge clk);
    rd2(MDU_ADDR_CTRL, {1'b1, 6'h00, m});
    chk(bus2.completion_irq, 1'b0);
    rd2(MDU_ADDR_CTRL, {7'h00, m});
    chk(bus2.completion_irq, 1'b1);
    rd_res(q, m ? 16'h0000 : 16'(a % b));
  endtask : run2
  task automatic host_op(input logic [48:0] op);
    logic [31:0] q;
    logic [15:0] r;
    int          n;
    q = op[48] ? op[31:16] * op[15:0] : op[47:16] / op[15:0];
    r = op[48] ? 16'h0000 : 16'(op[47:16] % op[15:0]);
    @(negedge clk);
    req_mul = op[48];
    req_a = op[47:16];
    req_b = op[15:0];
    req_valid = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    chk(req_ready, 1'b0);
    for (n = 0; rsp_valid !== 1'b1 && n < 200; n++) @(negedge clk);
    chk(rsp_valid, 1'b1);
    chk(req_ready, 1'b1);
    chk(rsp_result, q);
    chk(rsp_rem, r);
  endtask : host_op
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_host();
    logic [48:0] ops [6] = '{{1'b1, 32'h000000DA, 16'h0093}, {1'b0, 32'hDCBA2586, 16'h0018},
      {1'b1, 32'h0000FFFF, 16'hFFFF}, {1'b0, 32'hFFFFFFFF, 16'h0001},
      {1'b0, 32'h12345678, 16'hFFFF}, {1'b1, 32'h00001234, 16'h0000}};
    for (int i = 0; i < 6; i++) host_op(ops[i]);
    $display("t_host done");
  endtask : t_host
  task automatic t_regs();
    rd2(MDU_ADDR_CTRL, 8'h00);
    rd2(MDU_ADDR_REM_L, 8'h00);
    rd2(16'hFF69, 8'h00);
    bw2(3'd3, 1'b1);
    rd2(MDU_ADDR_CTRL, 8'h00);
    bw2(3'd0, 1'b1);
    rd2(MDU_ADDR_CTRL, 8'h01);
    wr2(MDU_ADDR_CTRL, 8'h7E);
    rd2(MDU_ADDR_CTRL, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_direct();
    run2(1'b1, 32'hAA5500DA, 16'h0093);
    run2(1'b0, 32'hDCBA2586, 16'h0018);
    run2(1'b1, 32'h0000FFFF, 16'hFFFF);
    $display("t_direct done");
  endtask : t_direct
  task automatic t_abort();
    int n;
    n = 0;
    ld2(32'h12345678, 16'h0007);
    wr2(MDU_ADDR_CTRL, MDU_CTRL_DIV);
    repeat (5) @(negedge clk);
    bw2(3'd7, 1'b0);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (bus2.completion_irq !== 1'b0) n++;
    end
    chk(n, 0);
    rd2(MDU_ADDR_CTRL, 8'h00);
    run2(1'b0, 32'h87654321, 16'h0123);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_late();
    ld2(32'h000000DA, 16'h0093);
    wr2(MDU_ADDR_CTRL, MDU_CTRL_MUL);
    repeat (14) @(negedge clk);
    bw2(3'd7, 1'b0);
    chk(bus2.completion_irq, 1'b1);
    rd_res(32'h00007D2E, 16'h0000);
    rd2(MDU_ADDR_CTRL, 8'h01);
    $display("t_late done");
  endtask : t_late
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    #(6000 * 40);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_mul = 1'b0;
    req_a = '0;
    req_b = '0;
    bus2.addr = MDU_ADDR_CTRL;
    bus2.wdata = 8'h00;
    bus2.wr_en = 1'b0;
    bus2.bit_wr = 1'b0;
    bus2.bit_sel = 3'd0;
    bus2.bit_val = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_host();
    t_direct();
    t_abort();
    t_late();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
